/* File: rtl/nfp_pkg.sv */
package nfp_pkg;

  // Status register bit positions
  localparam int SR_WIP_BIT = 0;
  localparam int SR_WEL_BIT = 1;
  localparam int SR_PROT_LSB_BIT = 2;
  localparam int SR_PROT_MID_BIT = 3;
  localparam int SR_PROT_HIGH_BIT = 4;
  localparam int SR_TOP_BOTTOM_BIT = 5;
  localparam int SR_PROT_MSB_BIT = 6;
  localparam int SR_WRITE_LOCK_BIT = 7;
  localparam logic [7:0] SR_RESET = 8'hA0;
  localparam logic [7:0] SR_NONVOL_MASK = 8'hFC;

  // Flag status register bit positions
  localparam int FS_ADDR4_BIT = 0;
  localparam int FS_PROT_ERR_BIT = 1;
  localparam int FS_PROG_ERR_BIT = 4;
  localparam int FS_ERASE_ERR_BIT = 5;
  localparam int FS_READY_BIT = 7;
  localparam logic [7:0] FS_RESET = 8'h80;
  localparam logic [7:0] FS_ERR_MASK = 8'h32;

  // Array geometry
  localparam int ADDR_W = 27;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 27'h7FF_FFFF;
  localparam int SECTOR_MSB = 26;
  localparam int SECTOR_LSB = 16;
  localparam int SECTOR_W = 11;
  localparam int SUB32_LSB = 15;
  localparam int SUB4_LSB = 12;
  localparam int PROT_CODE_W = 4;
  localparam logic [PROT_CODE_W-1:0] PROT_CODE_ALL = 4'hC;

  // Operation times, plain defaults, and their cycle counts
  localparam int CLK_PERIOD_NS = 10;
  localparam int TMR_W = 12;
  localparam int T_WRITE_STATUS_NS = 8000;
  localparam int T_WRITE_NVCFG_NS = 8000;
  localparam int T_PROGRAM_NS = 12000;
  localparam int T_ERASE_SUB_NS = 30000;
  localparam int T_ERASE_SECTOR_NS = 40000;
  localparam int T_ERASE_DIE_NS = 40000;
  localparam logic [TMR_W-1:0] CYC_WRITE_STATUS = 12'((T_WRITE_STATUS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CYC_WRITE_NVCFG = 12'((T_WRITE_NVCFG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CYC_PROGRAM = 12'((T_PROGRAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CYC_ERASE_SUB = 12'((T_ERASE_SUB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CYC_ERASE_SECTOR = 12'((T_ERASE_SECTOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CYC_ERASE_DIE = 12'((T_ERASE_DIE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    NFP_OP_NOP = 4'b0000,
    NFP_OP_WRITE_ENABLE = 4'b0001,
    NFP_OP_WRITE_DISABLE = 4'b0010,
    NFP_OP_READ_STATUS = 4'b0011,
    NFP_OP_WRITE_STATUS = 4'b0100,
    NFP_OP_READ_FLAGS = 4'b0101,
    NFP_OP_CLEAR_FLAGS = 4'b0110,
    NFP_OP_PROGRAM = 4'b0111,
    NFP_OP_ERASE_4K = 4'b1000,
    NFP_OP_ERASE_32K = 4'b1001,
    NFP_OP_ERASE_64K = 4'b1010,
    NFP_OP_ERASE_DIE = 4'b1011,
    NFP_OP_WRITE_NVCFG = 4'b1100
  } nfp_op_t;

  typedef enum logic [0:0] {
    NFP_ST_IDLE = 1'b0,
    NFP_ST_BUSY = 1'b1
  } nfp_state_t;

  typedef struct packed {
    nfp_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } nfp_cmd_t;

endpackage

/* File: rtl/nfp_prot_decode.sv */
`timescale 1ns/1ns
module nfp_prot_decode import nfp_pkg::*; (
  // Protection settings
  input wire logic top_bottom,
  input wire logic [PROT_CODE_W-1:0] block_protect_code,
  // Sector under test
  input wire logic [SECTOR_W-1:0] sector,
  // Result
  output logic protected_hit
);

  logic [SECTOR_W-1:0] fixed_bits;

  // A bit is fixed when the protected run is no wider than its weight
  genvar gi;
  generate
    for (gi = 0; gi < SECTOR_W; gi++) begin : g_mask
      assign fixed_bits[gi] = (block_protect_code <= 4'(gi + 1));
    end
  endgenerate

  always_comb begin
    if (block_protect_code == '0) begin
      protected_hit = 1'b0;
    end else if (block_protect_code >= PROT_CODE_ALL) begin
      protected_hit = 1'b1;
    end else if (!top_bottom) begin
      protected_hit = ((sector & fixed_bits) == fixed_bits);
    end else begin
      protected_hit = ((sector & fixed_bits) == '0);
    end
  end

endmodule

/* File: rtl/nfp_op_timer.sv */
`timescale 1ns/1ns
module nfp_op_timer import nfp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic start,
  input wire logic [TMR_W-1:0] cycles,
  // Status
  output logic done
);

  logic [TMR_W-1:0] count_q;
  logic running_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_q <= '0;
      running_q <= 1'b0;
    end else if (start) begin
      count_q <= cycles;
      running_q <= 1'b1;
    end else if (running_q) begin
      count_q <= count_q - 12'h001;
      running_q <= (count_q > 12'h001);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done <= 1'b0;
    end else begin
      done <= running_q && !start && (count_q == 12'h001);
    end
  end

endmodule

/* File: rtl/nfp_status_protect.sv */
`timescale 1ns/1ns
module nfp_status_protect import nfp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Host command port
  input wire logic cmd_valid,
  input wire nfp_cmd_t cmd,
  // Host answer port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // Write-protect pin
  input wire logic write_protect_n,
  // Array operation request
  output logic arr_valid,
  output nfp_cmd_t arr_req,
  // Register taps
  output logic [7:0] status_reg,
  output logic [7:0] flag_status
);

  nfp_state_t state_q;
  nfp_state_t state_d;
  logic [7:0] sr_q;
  logic [7:0] sr_d;
  logic [7:0] fs_q;
  logic [7:0] fs_d;
  logic [7:0] pend_status_q;
  logic pend_is_wrsr_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic arr_valid_q;
  nfp_cmd_t arr_req_q;

  logic idle;
  logic wel;
  logic write_locked;
  logic [PROT_CODE_W-1:0] block_protect_code;
  logic block_protect_msb;
  logic block_protect_lsb;
  logic [SECTOR_W-1:0] cmd_sector;
  logic sector_hit;
  logic is_array_op;
  logic is_erase;
  logic addr_ok;
  logic launch;
  logic reject;
  logic prot_fail;
  logic [TMR_W-1:0] launch_cycles;
  logic timer_done;
  logic [7:0] fs_set;
  logic [7:0] fs_clr;

  // Protection settings held in the status register
  assign block_protect_msb = sr_q[SR_PROT_MSB_BIT];
  assign block_protect_lsb = sr_q[SR_PROT_LSB_BIT];
  assign block_protect_code = {block_protect_msb, sr_q[SR_PROT_HIGH_BIT],
                               sr_q[SR_PROT_MID_BIT], block_protect_lsb};
  assign cmd_sector = cmd.addr[SECTOR_MSB:SECTOR_LSB];
  // Subsector erases are judged by the 64KB sector that holds them
  assign addr_ok = (cmd.addr <= ADDR_LAST);

  assign idle = (state_q == NFP_ST_IDLE);
  assign wel = sr_q[SR_WEL_BIT];
  assign write_locked = sr_q[SR_WRITE_LOCK_BIT] && !write_protect_n;

  nfp_prot_decode u_decode (
    .top_bottom(sr_q[SR_TOP_BOTTOM_BIT]),
    .block_protect_code(block_protect_code),
    .sector(cmd_sector),
    .protected_hit(sector_hit)
  );

  // One shared timer; its length is chosen by the operation at launch
  nfp_op_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(launch),
    .cycles(launch_cycles),
    .done(timer_done)
  );

  // Classify the incoming command
  always_comb begin
    is_array_op = 1'b0;
    is_erase = 1'b0;
    case (cmd.op)
      NFP_OP_PROGRAM: begin
        is_array_op = 1'b1;
      end
      NFP_OP_ERASE_4K, NFP_OP_ERASE_32K, NFP_OP_ERASE_64K, NFP_OP_ERASE_DIE: begin
        is_array_op = 1'b1;
        is_erase = 1'b1;
      end
      default: begin
        is_array_op = 1'b0;
        is_erase = 1'b0;
      end
    endcase
  end

  // Protection verdict for program and erase
  always_comb begin
    if (cmd.op == NFP_OP_ERASE_DIE) begin
      prot_fail = (block_protect_code != '0);
    end else begin
      prot_fail = sector_hit;
    end
  end

  // Launch or reject a modifying command
  always_comb begin
    launch = 1'b0;
    reject = 1'b0;
    launch_cycles = CYC_PROGRAM;
    if (cmd_valid && idle && wel) begin
      case (cmd.op)
        NFP_OP_WRITE_STATUS: begin
          launch = !write_locked;
          reject = write_locked;
          launch_cycles = CYC_WRITE_STATUS;
        end
        NFP_OP_WRITE_NVCFG: begin
          launch = 1'b1;
          launch_cycles = CYC_WRITE_NVCFG;
        end
        NFP_OP_PROGRAM: begin
          launch = !prot_fail && addr_ok;
          reject = prot_fail || !addr_ok;
          launch_cycles = CYC_PROGRAM;
        end
        NFP_OP_ERASE_4K, NFP_OP_ERASE_32K: begin
          launch = !prot_fail && addr_ok;
          reject = prot_fail || !addr_ok;
          launch_cycles = CYC_ERASE_SUB;
        end
        NFP_OP_ERASE_64K: begin
          launch = !prot_fail && addr_ok;
          reject = prot_fail || !addr_ok;
          launch_cycles = CYC_ERASE_SECTOR;
        end
        NFP_OP_ERASE_DIE: begin
          launch = !prot_fail;
          reject = prot_fail;
          launch_cycles = CYC_ERASE_DIE;
        end
        default: begin
          launch = 1'b0;
          reject = 1'b0;
          launch_cycles = CYC_PROGRAM;
        end
      endcase
    end
  end

  // Busy state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      NFP_ST_IDLE: begin
        if (launch) begin
          state_d = NFP_ST_BUSY;
        end
      end
      NFP_ST_BUSY: begin
        if (timer_done) begin
          state_d = NFP_ST_IDLE;
        end
      end
      default: begin
        state_d = NFP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= NFP_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Status register next value
  always_comb begin
    sr_d = sr_q;
    if (cmd_valid && idle && cmd.op == NFP_OP_WRITE_ENABLE) begin
      sr_d[SR_WEL_BIT] = 1'b1;
    end
    if (cmd_valid && idle && cmd.op == NFP_OP_WRITE_DISABLE) begin
      sr_d[SR_WEL_BIT] = 1'b0;
    end
    if (reject) begin
      sr_d[SR_WEL_BIT] = 1'b0;
    end
    if (timer_done) begin
      if (pend_is_wrsr_q) begin
        sr_d = (pend_status_q & SR_NONVOL_MASK) | (sr_q & ~SR_NONVOL_MASK);
      end
      sr_d[SR_WEL_BIT] = 1'b0;
    end
    sr_d[SR_WIP_BIT] = (state_d == NFP_ST_BUSY);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sr_q <= SR_RESET;
    end else begin
      sr_q <= sr_d;
    end
  end

  // Pending write-status value, applied when the cycle ends
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_status_q <= '0;
      pend_is_wrsr_q <= 1'b0;
    end else if (launch) begin
      pend_status_q <= cmd.data;
      pend_is_wrsr_q <= (cmd.op == NFP_OP_WRITE_STATUS);
    end
  end

  // Flag status: errors are sticky, a new error wins over a clear
  always_comb begin
    fs_set = '0;
    fs_clr = '0;
    if (cmd_valid && idle && wel && is_array_op && prot_fail) begin
      fs_set[FS_PROT_ERR_BIT] = 1'b1;
      fs_set[FS_ERASE_ERR_BIT] = is_erase;
      fs_set[FS_PROG_ERR_BIT] = !is_erase;
    end
    if (cmd_valid && idle && cmd.op == NFP_OP_CLEAR_FLAGS) begin
      fs_clr = FS_ERR_MASK;
    end
    fs_d = (fs_q & ~fs_clr) | fs_set;
    fs_d[FS_READY_BIT] = (state_d != NFP_ST_BUSY);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fs_q <= FS_RESET;
    end else begin
      fs_q <= fs_d;
    end
  end

  // Register read answers, taken in any state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      rsp_valid_q <= cmd_valid && (cmd.op == NFP_OP_READ_STATUS || cmd.op == NFP_OP_READ_FLAGS);
      if (cmd_valid && cmd.op == NFP_OP_READ_STATUS) begin
        rsp_data_q <= sr_q;
      end else if (cmd_valid && cmd.op == NFP_OP_READ_FLAGS) begin
        rsp_data_q <= fs_q;
      end
    end
  end

  // Request to the array for accepted modifications
  // Write-status stays inside the block and is not passed to the array
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arr_valid_q <= 1'b0;
      arr_req_q <= '0;
    end else begin
      arr_valid_q <= launch && (cmd.op != NFP_OP_WRITE_STATUS);
      if (launch) begin
        arr_req_q <= cmd;
      end
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign arr_valid = arr_valid_q;
  assign arr_req = arr_req_q;
  assign status_reg = sr_q;
  assign flag_status = fs_q;

endmodule

/* File: test/nfp_status_protect_assertions.sv */
`timescale 1ns/1ns
module nfp_status_protect_chk import nfp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Host side
  input wire logic cmd_valid,
  input wire nfp_cmd_t cmd,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic write_protect_n,
  // Array side and taps
  input wire logic arr_valid,
  input wire nfp_cmd_t arr_req,
  input wire logic [7:0] status_reg,
  input wire logic [7:0] flag_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic idle;
  logic [3:0] code;
  assign idle = cmd_valid && !status_reg[0];
  assign code = {status_reg[6], status_reg[4:2]};
  a_busy_inverse: assert property (
    status_reg[0] == !flag_status[7]) else $error("busy and ready disagree");
  a_read_answer: assert property (
    cmd_valid && cmd.op == NFP_OP_READ_STATUS |=> rsp_valid && rsp_data == $past(status_reg))
    else $error("bad status answer");
  a_lock_holds: assert property (
    idle && cmd.op == NFP_OP_WRITE_STATUS && status_reg[7] && !write_protect_n
    |=> !status_reg[0] && status_reg[7:2] == $past(status_reg[7:2])) else $error("locked write ran");
  a_wel_gate: assert property (
    idle && cmd.op == NFP_OP_PROGRAM && !status_reg[1] |=> !arr_valid && !status_reg[0])
    else $error("program ran without latch");
  a_wel_set: assert property (
    idle && cmd.op == NFP_OP_WRITE_ENABLE |=> status_reg[1]) else $error("latch not set");
  a_die_guard: assert property (
    idle && cmd.op == NFP_OP_ERASE_DIE && code != 4'h0 && status_reg[1]
    |=> !arr_valid ##[0:2] (flag_status[1] && flag_status[5])) else $error("die erase not refused");
  a_launch_wel: assert property (
    arr_valid |-> $past(status_reg[1])) else $error("launch without latch");
  a_busy_hold: assert property (
    arr_valid |-> status_reg[0] [*8]) else $error("busy dropped early");
  a_wel_clear: assert property (
    $fell(status_reg[0]) |-> !status_reg[1]) else $error("latch kept after completion");
endmodule
bind nfp_status_protect nfp_status_protect_chk chk(.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
  .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .write_protect_n(write_protect_n),
  .arr_valid(arr_valid), .arr_req(arr_req), .status_reg(status_reg), .flag_status(flag_status));

/* File: test/nfp_host_model.sv */
`timescale 1ns/1ns
module nfp_host_model import nfp_pkg::*; (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_valid,
  output nfp_cmd_t cmd,
  // Write-protect pin
  output logic write_protect_n
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    write_protect_n = 1'b0;
  end
  // Fields are scrambled between strobes so stale values never look valid
  task automatic send(input nfp_op_t op, input logic [ADDR_W-1:0] addr, input logic [7:0] data);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{op, addr, data};
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd = ~cmd;
  endtask
  task automatic set_wp(input logic lvl);
    @(negedge clk);
    write_protect_n = lvl;
  endtask
endmodule

/* File: test/nfp_status_protect_tb_top.sv */
`timescale 1ns/1ns
module nfp_status_protect_tb_top import nfp_pkg::*; ();
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid, write_protect_n, rsp_valid, arr_valid, p;
  nfp_cmd_t cmd, arr_req;
  logic [7:0] rsp_data, status_reg, flag_status, sr;
  logic [10:0] s;
  logic [26:0] a;
  nfp_op_t op_sel;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] rsp_q[$];
  nfp_cmd_t arr_q[$];
  always #5 clk = ~clk;
  nfp_host_model host(.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .write_protect_n(write_protect_n));
  nfp_status_protect uut(.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .write_protect_n(write_protect_n), .arr_valid(arr_valid),
    .arr_req(arr_req), .status_reg(status_reg), .flag_status(flag_status));
  task automatic check(input logic [38:0] seen, input logic [38:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic prot(input logic tb, input logic [3:0] c, input logic [10:0] sec);
    if (c == 4'h0) return 1'b0;
    if (c >= 4'hC) return 1'b1;
    return tb ? (12'(sec) < (12'd1 << (c - 1))) : (12'(sec) >= 12'd2048 - (12'd1 << (c - 1)));
  endfunction
  // Results settle after the rising edge, so they are taken at the falling edge
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) check(39'(rsp_data), rsp_q.size() ? 39'(rsp_q.pop_front()) : '1);
    if (arr_valid === 1'b1) check(arr_req, arr_q.size() ? arr_q.pop_front() : '1);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 90000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic rd(input logic [7:0] exp_sr, input logic [7:0] exp_fs);
    rsp_q.push_back(exp_sr);
    host.send(NFP_OP_READ_STATUS, '0, '0);
    rsp_q.push_back(exp_fs);
    host.send(NFP_OP_READ_FLAGS, '0, '0);
  endtask
  task automatic mod(input nfp_op_t o, input logic [26:0] ad, input logic [7:0] d, input logic busy);
    host.send(NFP_OP_WRITE_ENABLE, '0, '0);
    check(39'(status_reg[1]), 39'(1'b1));
    host.send(o, ad, d);
    check(39'({status_reg[0], flag_status[7]}), 39'({busy, !busy}));
    for (int n = 0; n < 5000 && status_reg[0] !== 1'b0; n++) @(negedge clk);
    check(39'(status_reg[0]), 39'(1'b0));
  endtask
  initial begin
    void'($urandom(47620));
    repeat (3) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    check(39'(status_reg), 39'(8'hA0));
    rd(8'hA0, 8'h80);
    host.send(NFP_OP_PROGRAM, '0, '0);
    check(39'(status_reg[0]), 39'(1'b0));
    host.send(NFP_OP_WRITE_ENABLE, '0, '0);
    host.send(NFP_OP_WRITE_DISABLE, '0, '0);
    check(39'(status_reg[1]), 39'(1'b0));
    mod(NFP_OP_WRITE_STATUS, '0, 8'h00, 1'b0);
    rd(8'hA0, 8'h80);
    host.set_wp(1'b1);
    for (int t = 1; t >= 0; t--) begin
      for (int c = 0; c < 16; c++) begin
        sr = {1'b0, c[3], t[0], c[2:0], 2'b00};
        mod(NFP_OP_WRITE_STATUS, '0, sr | 8'h03, 1'b1);
        // Edge sector of the protected run, the one just outside it, or any sector
        s = t ? 11'((1 << (c - 1)) - 1) : 11'(2048 - (1 << (c - 1)));
        case ($urandom_range(2))
          0: s = 11'($urandom);
          1: s = t ? s + 11'h001 : s - 11'h001;
          default: s = s;
        endcase
        a = {s, 16'($urandom)};
        p = prot(t[0], c[3:0], s);
        // Refused requests are cheap, so they also try the 4KB, 32KB and 64KB erases
        op_sel = p ? nfp_op_t'(4'(NFP_OP_PROGRAM) + 4'($urandom_range(3))) : NFP_OP_PROGRAM;
        if (!p) arr_q.push_back('{op_sel, a, 8'h5A});
        mod(op_sel, a, 8'h5A, !p);
        rd(sr, !p ? 8'h80 : (op_sel == NFP_OP_PROGRAM ? 8'h92 : 8'hA2));
        host.send(NFP_OP_CLEAR_FLAGS, '0, '0);
      end
    end
    mod(NFP_OP_ERASE_DIE, '0, '0, 1'b0);
    rd(sr, 8'hA2);
    host.send(NFP_OP_CLEAR_FLAGS, '0, '0);
    mod(NFP_OP_WRITE_STATUS, '0, 8'h00, 1'b1);
    arr_q.push_back('{NFP_OP_ERASE_DIE, 27'h000_0000, 8'h00});
    mod(NFP_OP_ERASE_DIE, '0, '0, 1'b1);
    a = 27'($urandom);
    arr_q.push_back('{NFP_OP_ERASE_32K, a, 8'h00});
    mod(NFP_OP_ERASE_32K, a, '0, 1'b1);
    arr_q.push_back('{NFP_OP_WRITE_NVCFG, 27'h000_0000, 8'h3C});
    mod(NFP_OP_WRITE_NVCFG, '0, 8'h3C, 1'b1);
    rd(8'h00, 8'h80);
    repeat (4) @(negedge clk);
    check(39'(rsp_q.size() + arr_q.size()), 39'(0));
    final_report();
  end
endmodule
